// ### logic/bias_routing_pkg.sv
// constants and carrier types for the excitation routing and bias select registers
// assumes a register port that delivers one byte-wide access per cycle
package bias_routing_pkg;

    localparam int unsigned  ADDR_W                = 8;
    localparam int unsigned  DATA_W                = 8;
    localparam int unsigned  SEL_W                 = 4;
    localparam int unsigned  NUM_ROUTED_INPUTS     = 7;
    localparam int unsigned  NUM_BIASED_INPUTS     = 6;

    // register offsets
    localparam logic [7:0]   ROUTING_ADDR          = 8'h07;
    localparam logic [7:0]   BIAS_ADDR             = 8'h08;

    // reset values
    localparam logic [7:0]   ROUTING_RESET         = 8'hFF;
    localparam logic [7:0]   BIAS_RESET            = 8'h00;

    // field positions
    localparam int unsigned  SECOND_SEL_LSB        = 4;
    localparam int unsigned  FIRST_SEL_LSB         = 0;
    localparam int unsigned  BIAS_COMMON_BIT       = 6;
    localparam int unsigned  BIAS_RESERVED_BIT     = 7;

    // highest legal routing code, above it the source goes nowhere
    localparam logic [3:0]   MAX_INPUT_CODE        = 4'h6;

    // one register access from the serial interface logic
    typedef struct packed {
        logic                valid;
        logic                write;
        logic [7:0]          addr;
        logic [7:0]          wdata;
    } reg_req_s;

    // switch controls for the analog front end: one-hot or zero per source route, any mix of bias enables
    typedef struct packed {
        logic [6:0]          first_source_route;
        logic [6:0]          second_source_route;
        logic [5:0]          bias_to_inputs;
        logic                bias_to_common_input;
    } analog_ctrl_s;

endpackage

// ### logic/route_decoder.sv
// one 4-bit routing code to one-hot input switch enables
// assumes a code from a register on the same clock
`timescale 1ns/1ps
`default_nettype none
module route_decoder #(
    parameter int unsigned SEL_WIDTH = 4,
    parameter int unsigned OUTPUTS   = 7
) (
    // code in
    input  wire logic [SEL_WIDTH-1:0] code,
    // one-hot out, all zero for codes beyond the last input
    output logic      [OUTPUTS-1:0]   onehot
);
    // elaboration check: every output needs a code of its own
    if (OUTPUTS > (1 << SEL_WIDTH)) begin : g_bad_width
        $error("route_decoder: too many outputs for code width");
    end

    // codes past the last input connect nothing, so an idle source stays open
    always_comb begin
        onehot = '0;
        for (int i = 0; i < int'(OUTPUTS); i++) begin
            if (code == SEL_WIDTH'(i)) onehot[i] = 1'b1;
        end
    end
endmodule
`default_nettype wire

// ### logic/excitation_bias_routing_regs.sv
// routing register for two matched current sources and bias select register
// assumes the serial interface logic presents decoded accesses on core_clk
// assumes that logic runs on core_clk, so no access input needs a synchroniser
// Function
// - routing register at 07h, read/write, resets to FFh
// - bits 3:0 route the first source with the same encoding
// - bias register at 08h, read/write, resets to 00h, all open
// - bias bit 6 connects the bias voltage to the common input
// - bias bits 0..5 connect the bias voltage to inputs 0..5
// - any combination of bias bits may be set together
`timescale 1ns/1ps
`default_nettype none

module excitation_bias_routing_regs #(
    // number of analog inputs a current source can be steered to
    parameter int unsigned ROUTED_INPUTS = bias_routing_pkg::NUM_ROUTED_INPUTS,
    // number of plain analog inputs the bias voltage can reach
    parameter int unsigned BIASED_INPUTS = bias_routing_pkg::NUM_BIASED_INPUTS,
    // width of one routing code field
    parameter int unsigned SEL_WIDTH     = bias_routing_pkg::SEL_W
) (
    // clock and reset
    input  wire logic                           core_clk,
    input  wire logic                           rst,
    // register access
    input  wire bias_routing_pkg::reg_req_s     req,
    output logic [bias_routing_pkg::DATA_W-1:0] rdata,
    output logic                                rvalid,
    // analog switch controls
    output var bias_routing_pkg::analog_ctrl_s  analog_ctrl
);
    import bias_routing_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // elaboration checks
    // the switch carrier in the package has fixed field widths, so a count
    // that differs from it cannot be served without changing the package too
    if (ROUTED_INPUTS != NUM_ROUTED_INPUTS) begin : g_bad_routed
        $error("routed input count does not match the switch carrier");
    end

    if (BIASED_INPUTS != NUM_BIASED_INPUTS) begin : g_bad_biased
        $error("biased input count does not match the switch carrier");
    end

    // the two code fields must fill the routing byte exactly
    if (2 * SEL_WIDTH != DATA_W) begin : g_bad_sel
        $error("two routing fields must fill one register byte");
    end

    // a code field must be wide enough to name every routed input
    if (ROUTED_INPUTS > (1 << SEL_WIDTH)) begin : g_bad_code
        $error("routing code too narrow for the routed input count");
    end

    // plain bias bits, the common bit and the reserved bit fill one byte
    if (BIASED_INPUTS + 2 != DATA_W) begin : g_bad_bias
        $error("bias fields must fill one register byte");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // storage, one flip-flop group per register field

    // routing fields
    logic [SEL_WIDTH-1:0]       second_sel_q;
    logic [SEL_WIDTH-1:0]       first_sel_q;

    // bias fields
    logic [BIASED_INPUTS-1:0]   bias_inputs_q;
    logic                       bias_common_q;
    logic                       bias_reserved_q;

    // whole-byte views of the two registers for read back
    logic [DATA_W-1:0]          routing_view;
    logic [DATA_W-1:0]          bias_view;

    // decoded accesses
    logic                       wr_routing;
    logic                       wr_bias;
    logic                       rd_any;
    logic [DATA_W-1:0]          rd_data_d;

    // decoder outputs, one-hot or all zero
    logic [ROUTED_INPUTS-1:0]   first_route;
    logic [ROUTED_INPUTS-1:0]   second_route;

    ////////////////////////////////////////////////////////////////////////////////
    // access decode
    // the access port gives one request per cycle, so a write and a read
    // never meet in one cycle and need no priority between them
    assign wr_routing = req.valid && req.write && (req.addr == ROUTING_ADDR);
    assign wr_bias    = req.valid && req.write && (req.addr == BIAS_ADDR);
    assign rd_any     = req.valid && !req.write;

    ////////////////////////////////////////////////////////////////////////////////
    // routing register

    // second source code in the upper field
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            second_sel_q <= ROUTING_RESET[SECOND_SEL_LSB +: SEL_WIDTH];
        end else if (wr_routing) begin
            second_sel_q <= req.wdata[SECOND_SEL_LSB +: SEL_WIDTH];
        end
    end

    // first source code in the lower field
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            first_sel_q <= ROUTING_RESET[FIRST_SEL_LSB +: SEL_WIDTH];
        end else if (wr_routing) begin
            first_sel_q <= req.wdata[FIRST_SEL_LSB +: SEL_WIDTH];
        end
    end

    // both fields read back as one byte
    assign routing_view = {second_sel_q, first_sel_q};

    ////////////////////////////////////////////////////////////////////////////////
    // bias register

    // plain input enables; any mix may be set at once
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bias_inputs_q <= BIAS_RESET[BIASED_INPUTS-1:0];
        end else if (wr_bias) begin
            bias_inputs_q <= req.wdata[BIASED_INPUTS-1:0];
        end
    end

    // common input enable
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bias_common_q <= BIAS_RESET[BIAS_COMMON_BIT];
        end else if (wr_bias) begin
            bias_common_q <= req.wdata[BIAS_COMMON_BIT];
        end
    end

    // reserved bit is kept as written so a read shows what software wrote;
    // it drives no switch, so a stray one does no harm to the front end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bias_reserved_q <= BIAS_RESET[BIAS_RESERVED_BIT];
        end else if (wr_bias) begin
            bias_reserved_q <= req.wdata[BIAS_RESERVED_BIT];
        end
    end

    // the whole byte for read back
    assign bias_view = {bias_reserved_q, bias_common_q, bias_inputs_q};

    ////////////////////////////////////////////////////////////////////////////////
    // read port

    // read data select; unmapped offsets read zero rather than stale data
    always_comb begin
        rd_data_d = '0;
        case (req.addr)
            ROUTING_ADDR: rd_data_d = routing_view;
            BIAS_ADDR:    rd_data_d = bias_view;
            default:      rd_data_d = '0;
        endcase
    end

    // read data taken one cycle after the request and held until the next
    // read, so a slow consumer may pick it up late
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata <= '0;
        end else if (rd_any) begin
            rdata <= rd_data_d;
        end
    end

    // one-cycle marker that rdata has just been loaded
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rvalid <= 1'b0;
        end else begin
            rvalid <= rd_any;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // code decoders for the two sources

    // first source
    route_decoder #(
        .SEL_WIDTH (SEL_WIDTH),
        .OUTPUTS   (ROUTED_INPUTS)
    ) u_first_decoder (
        .code      (first_sel_q),
        .onehot    (first_route)
    );

    // second source, same encoding as the first
    route_decoder #(
        .SEL_WIDTH (SEL_WIDTH),
        .OUTPUTS   (ROUTED_INPUTS)
    ) u_second_decoder (
        .code      (second_sel_q),
        .onehot    (second_route)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // switch controls
    // registered so the analog side sees glitch-free levels while the
    // decoders settle; this costs one cycle of latency after a write
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            analog_ctrl <= '0;
        end else begin
            analog_ctrl.first_source_route   <= first_route;
            analog_ctrl.second_source_route  <= second_route;
            analog_ctrl.bias_to_inputs       <= bias_inputs_q;
            analog_ctrl.bias_to_common_input <= bias_common_q;
        end
    end

endmodule

`default_nettype wire

// ### dv/bias_routing_chk.sv
// checker for the register block ports
// assumes a bind onto the register block
`timescale 1ns/1ps
`default_nettype none
module bias_routing_chk import bias_routing_pkg::*; (
    input wire logic         core_clk,
    input wire logic         rst,
    input wire reg_req_s     req,
    input wire logic [7:0]   rdata,
    input wire logic         rvalid,
    input wire analog_ctrl_s analog_ctrl
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // a write, then a read of the same offset, so no later write hides it
    sequence wr_rd_s(a);
        req.valid && req.write && req.addr == a ##1 req.valid && !req.write && req.addr == a;
    endsequence
    AST_RD: assert property (req.valid && !req.write |=> rvalid) else $error("no rvalid");
    AST_ROUTE: assert property (wr_rd_s(8'h07) |=> analog_ctrl[20:7] == {
        7'(8'h01 << $past(req.wdata[3:0], 2)), 7'(8'h01 << $past(req.wdata[7:4], 2))})
        else $error("routing");
    AST_BIAS: assert property (wr_rd_s(8'h08) |=> analog_ctrl[6:0] ==
        {$past(req.wdata[5:0], 2), $past(req.wdata[6], 2)}) else $error("bias");
    AST_RV_PULSE: assert property (!(req.valid && !req.write) |=> !rvalid)
        else $error("rvalid without read");
    AST_HOLD: assert property (!(req.valid && !req.write) |=> $stable(rdata))
        else $error("rdata moved without read");
    AST_ONEHOT: assert property ($onehot0(analog_ctrl.first_source_route) &&
        $onehot0(analog_ctrl.second_source_route)) else $error("route not one-hot");
    AST_RD_ROUTE: assert property (wr_rd_s(8'h07) |=> rdata == $past(req.wdata, 2))
        else $error("routing readback");
    AST_RD_BIAS: assert property (wr_rd_s(8'h08) |=> rdata == $past(req.wdata, 2))
        else $error("bias readback");
endmodule
bind excitation_bias_routing_regs bias_routing_chk u_chk (.core_clk(core_clk), .rst(rst),
    .req(req), .rdata(rdata), .rvalid(rvalid), .analog_ctrl(analog_ctrl));
`default_nettype wire

// ### dv/tb_excitation_bias_routing_regs.sv
// bench for the routing and bias registers
// assumes the block and its checker
`timescale 1ns/1ps
`default_nettype none
module tb_excitation_bias_routing_regs;
    import bias_routing_pkg::*;
    logic         core_clk = 1'b0;
    logic         rst = 1'b1;
    reg_req_s     req = '0;
    logic [7:0]   rdata;
    logic         rvalid;
    analog_ctrl_s ac;
    int           errors = 0;
    int           total_checks = 0;
    excitation_bias_routing_regs dut (.core_clk(core_clk), .rst(rst), .req(req),
        .rdata(rdata), .rvalid(rvalid), .analog_ctrl(ac));
    initial forever #4 core_clk = ~core_clk;
    // x never matches
    task automatic cmp(input logic [31:0] g, e);
        total_checks++;
        if (g !== e) errors++;
        if (g !== e) $display("mismatch %0t got %0h exp %0h", $time, g, e);
    endtask
    // a write stands for one rising edge; the request stays up for the next task
    task automatic wr(input logic [7:0] a, d);
        req = '{1'b1, 1'b1, a, d};
        @(negedge core_clk);
    endtask
    // a read, then a bounded wait for the rvalid pulse
    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        req = '{1'b1, 1'b0, a, 8'h00};
        @(negedge core_clk);
        while (rvalid !== 1'b1 && n < 4) begin
            n++;
            @(negedge core_clk);
        end
        if (n == 4) begin
            errors++;
            give_verdict();
        end
        cmp(rvalid, 1'b1);
    endtask
    // one idle cycle: the rvalid pulse ends and rdata holds
    task automatic idle(input logic [7:0] held);
        req = '0;
        @(negedge core_clk);
        cmp({rvalid, rdata}, {1'b0, held});
    endtask
    // reset, then each code on both fields
    task automatic routes();
        rd(ROUTING_ADDR);
        cmp({rdata, ac}, {ROUTING_RESET, 21'h0});
        idle(ROUTING_RESET);
        for (int c = 0; c < 16; c++) begin
            wr(ROUTING_ADDR, {c[3:0], ~c[3:0]});
            rd(ROUTING_ADDR);
            cmp({rdata, ac}, {c[3:0], ~c[3:0], 7'(8'h01 << (15 - c)),
                7'(8'h01 << c), 7'h00});
            idle({c[3:0], ~c[3:0]});
        end
    endtask
    // bias bits added one by one, bit 7 kept zero
    task automatic biases();
        for (logic [7:0] b = 8'h01; b != 8'hFF; b = {b[6:0], 1'b1}) begin
            wr(BIAS_ADDR, b);
            rd(BIAS_ADDR);
            cmp({rdata, ac}, {b, 14'h0080, b[5:0], b[6]});
            idle(b);
        end
    endtask
    // unmapped offsets: writes ignored, reads give zero with rvalid
    task automatic unmapped();
        wr(8'h09, 8'h5A);
        rd(8'h09);
        cmp(rdata, 8'h00);
        idle(8'h00);
        rd(BIAS_ADDR);
        cmp(rdata, 8'h7F);
        idle(8'h7F);
    endtask
    // reset in mid-run brings both registers and the switches back
    task automatic reset_mid();
        rst = 1'b1;
        repeat (2) @(negedge core_clk);
        cmp({rdata, rvalid, ac}, 30'h0);
        rst = 1'b0;
        rd(ROUTING_ADDR);
        cmp({rdata, ac}, {ROUTING_RESET, 21'h0});
        rd(BIAS_ADDR);
        cmp({rdata, ac}, {BIAS_RESET, 21'h0});
        idle(BIAS_RESET);
    endtask
    task automatic give_verdict();
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge core_clk);
        rst = 1'b0;
        routes();
        biases();
        unmapped();
        reset_mid();
        give_verdict();
    end
endmodule
`default_nettype wire
